/* File: include/gate_sup_pkg.sv */
// Shared constants, types and state layout of the gate driver supervisor.
// Assumes a single 10 MHz system clock; every time is converted to cycles here.
package gate_sup_pkg;

  localparam int CLK_NS = 100;
  localparam int CNT_W  = 17;
  typedef logic [CNT_W-1:0] cnt_t;

  // Times in their printed units.
  localparam int BLANK_NS    = 500;
  localparam int UV_EXTRA_NS = 700;
  localparam int OV_MIN_US   = 3;
  localparam int OV_TYP_US   = 5;
  localparam int POWER_MS    = 10;
  localparam int MOTOR_MS    = 5;
  localparam int ENLOW_MS    = 1;
  localparam int CLR_MIN_US  = 1;
  localparam int CLR_MAX_US  = 900;

  // Cycle counts: least times round up, longest times round down.
  localparam int BLANK_CYC   = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int UV_CYC      = (BLANK_NS + UV_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam int OV_MIN_CYC  = (OV_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int OV_TYP_CYC  = OV_TYP_US * 1000 / CLK_NS;
  localparam int OV_CYC      = (OV_TYP_CYC < OV_MIN_CYC) ? OV_MIN_CYC : OV_TYP_CYC;
  localparam int POWER_CYC   = POWER_MS * 1000000 / CLK_NS;
  localparam int MOTOR_CYC   = MOTOR_MS * 1000000 / CLK_NS;
  localparam int ENLOW_CYC   = ENLOW_MS * 1000000 / CLK_NS;
  localparam int CLR_MIN_CYC = (CLR_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CLR_MAX_CYC = CLR_MAX_US * 1000 / CLK_NS;

  localparam logic [1:0] SC_THR_RESET = 2'h0;
  localparam logic [2:0] PHASES_OFF   = 3'h0;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_STANDBY = 3'h1,
    ST_ARMING  = 3'h3,
    ST_OPER    = 3'h2,
    ST_SLEEP   = 3'h6
  } power_state_e;

  typedef struct packed {
    logic       enable;
    logic [2:0] pwmHigh;
    logic [2:0] pwmLow;
    logic [2:0] scHigh;
    logic [2:0] scLow;
    logic       overvoltageLockout;
    logic       undervoltageLockout;
    logic       overcurrentProtection;
    logic       otherFault;
  } pins_s;

  typedef struct packed {
    logic shortCircuit;
    logic undervoltageLockout;
    logic overvoltageLockout;
    logic overcurrentProtection;
    logic other;
  } fault_s;

  localparam fault_s NO_FAULTS = '0;

  typedef struct packed {
    logic       sleep;
    logic [1:0] shortCircuitThreshold;
  } config_reg_zero_s;

  typedef struct packed {
    power_state_e state;
    fault_s       faults;
    logic [2:0]   gateHigh;
    logic [2:0]   gateLow;
    logic [1:0]   threshold;
    logic         enPrev;
    logic         scPend;
    cnt_t         blankCnt;
    cnt_t         uvCnt;
    cnt_t         ovCnt;
    cnt_t         lowCnt;
    cnt_t         seqCnt;
  } sup_state_s;

endpackage

/* File: rtl/pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Pins and qualified levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s cur_r;
  sync_s cur_nxt;

  // The first stage feeds only the second; a level counts once stages two and three agree.
  always_comb begin
    cur_nxt    = cur_r;
    cur_nxt.s1 = din;
    cur_nxt.s2 = cur_r.s1;
    cur_nxt.s3 = cur_r.s2;
    for (int i = 0; i < W; i++) begin
      if (cur_r.s2[i] == cur_r.s3[i]) begin
        cur_nxt.q[i] = cur_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign dout = cur_r.q;

endmodule

/* File: rtl/gate_driver_fault_state_supervisor.sv */
// Power state sequencing and fault shutdown of a three-phase gate driver.
// Assumes analog comparators deliver asynchronous fault levels and the
// controller drives the enable and PWM pins; reset stands for power-up.
`timescale 1ns/1ns
// Notes on behaviour
// - Two-bit code selects short-circuit threshold, default 00.
// - Short circuit after blanking turns drivers off fast.
// - Overvoltage synchronised, drivers off after 3-5 us; drivers here go off 5.3-5.4 us after the pin rises.
// - Power-up or wake reaches standby after settling.
// - Standby to operational within variant limit.
// - Faults force gate outputs off promptly.
// - Enable low turns gates off within 250 ns; gates here go off 400-500 ns after the pin falls.
// - Sleep bit 0: standby 1 ms after enable low.
// - Sleep bit 1: sleep 1 ms after enable low.
// - Enable low pulse 1-900 us clears latched faults.
// - Undervoltage latched after blanking plus 700 ns.
module gate_driver_fault_state_supervisor #(
  parameter int POWER_CYCLES  = gate_sup_pkg::POWER_CYC,
  parameter int MOTOR_CYCLES  = gate_sup_pkg::MOTOR_CYC,
  parameter int ENLOW_CYCLES  = gate_sup_pkg::ENLOW_CYC,
  parameter int CLRMAX_CYCLES = gate_sup_pkg::CLR_MAX_CYC
) (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // Asynchronous pins and comparator levels
  input  wire gate_sup_pkg::pins_s            pins,
  // Configuration from the same clock domain
  input  wire gate_sup_pkg::config_reg_zero_s configRegZero,
  // Gate drive
  output logic [2:0]                          gateHigh,
  output logic [2:0]                          gateLow,
  // Analog threshold select and status
  output logic [1:0]                          shortCircuitThreshold,
  output gate_sup_pkg::power_state_e          powerState,
  output gate_sup_pkg::fault_s                faults,
  output logic                                faultActive
);

  gate_sup_pkg::pins_s      pin;
  gate_sup_pkg::sup_state_s cur_r;
  gate_sup_pkg::sup_state_s cur_nxt;

  pin_sync #(
    .W ($bits(gate_sup_pkg::pins_s))
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (pins),
    .dout    (pin)
  );

  function automatic gate_sup_pkg::cnt_t sat_inc(input gate_sup_pkg::cnt_t c,
                                                 input int lim);
    gate_sup_pkg::cnt_t l;
    l = gate_sup_pkg::cnt_t'(lim);
    sat_inc = (c >= l) ? l : c + gate_sup_pkg::cnt_t'(1);
  endfunction

  logic                 enRise;
  logic                 clearPulse;
  logic                 lowDone;
  logic                 scRaw;
  logic                 driveOn;
  logic                 gateRise;
  gate_sup_pkg::fault_s setF;

  always_comb begin
    cur_nxt    = cur_r;
    setF       = gate_sup_pkg::NO_FAULTS;
    enRise     = pin.enable & ~cur_r.enPrev;
    cur_nxt.enPrev = pin.enable;
    cur_nxt.threshold = configRegZero.shortCircuitThreshold;

    // Enable low time decides between a fault clear and a shutdown.
    if (!pin.enable) begin
      cur_nxt.lowCnt = sat_inc(cur_r.lowCnt, ENLOW_CYCLES);
    end else begin
      cur_nxt.lowCnt = '0;
    end
    clearPulse = enRise
      && cur_r.lowCnt >= gate_sup_pkg::cnt_t'(gate_sup_pkg::CLR_MIN_CYC)
      && cur_r.lowCnt <= gate_sup_pkg::cnt_t'(CLRMAX_CYCLES);
    lowDone = !pin.enable
      && cur_r.lowCnt == gate_sup_pkg::cnt_t'(ENLOW_CYCLES - 1);

    // Undervoltage must persist past the blanking time plus margin.
    if (pin.undervoltageLockout) begin
      cur_nxt.uvCnt = sat_inc(cur_r.uvCnt, gate_sup_pkg::UV_CYC);
    end else begin
      cur_nxt.uvCnt = '0;
    end
    setF.undervoltageLockout = pin.undervoltageLockout
      && cur_r.uvCnt == gate_sup_pkg::cnt_t'(gate_sup_pkg::UV_CYC - 1);

    // Overvoltage is held off briefly so supply transients do not trip the bridge.
    if (pin.overvoltageLockout) begin
      cur_nxt.ovCnt = sat_inc(cur_r.ovCnt, gate_sup_pkg::OV_CYC);
    end else begin
      cur_nxt.ovCnt = '0;
    end
    setF.overvoltageLockout = pin.overvoltageLockout
      && cur_r.ovCnt == gate_sup_pkg::cnt_t'(gate_sup_pkg::OV_CYC - 1);

    setF.overcurrentProtection = pin.overcurrentProtection;
    setF.other                 = pin.otherFault;

    // Short-circuit comparators are only believed on a phase being driven.
    scRaw = |((pin.scHigh & cur_r.gateHigh) | (pin.scLow & cur_r.gateLow));
    if (cur_r.blankCnt != '0) begin
      cur_nxt.blankCnt = cur_r.blankCnt - gate_sup_pkg::cnt_t'(1);
      cur_nxt.scPend   = cur_r.scPend | scRaw;
    end else begin
      setF.shortCircuit = scRaw | cur_r.scPend;
      cur_nxt.scPend    = 1'b0;
    end

    // A new fault wins over a clear arriving in the same cycle.
    cur_nxt.faults = (cur_r.faults & ~{$bits(gate_sup_pkg::fault_s){clearPulse}}) | setF;

    case (cur_r.state)
      gate_sup_pkg::ST_POWERUP: begin
        cur_nxt.seqCnt = cur_r.seqCnt + gate_sup_pkg::cnt_t'(1);
        if (cur_r.seqCnt >= gate_sup_pkg::cnt_t'(POWER_CYCLES - 1)) begin
          cur_nxt.state  = gate_sup_pkg::ST_STANDBY;
          cur_nxt.seqCnt = '0;
        end
      end
      gate_sup_pkg::ST_SLEEP: begin
        cur_nxt.seqCnt = '0;
        if (pin.enable) begin
          cur_nxt.state = gate_sup_pkg::ST_POWERUP;
        end
      end
      gate_sup_pkg::ST_STANDBY: begin
        cur_nxt.seqCnt = '0;
        if (pin.enable) begin
          cur_nxt.state = gate_sup_pkg::ST_ARMING;
        end else if (lowDone && configRegZero.sleep) begin
          cur_nxt.state = gate_sup_pkg::ST_SLEEP;
        end
      end
      gate_sup_pkg::ST_ARMING: begin
        if (pin.enable) begin
          cur_nxt.seqCnt = cur_r.seqCnt + gate_sup_pkg::cnt_t'(1);
          if (cur_r.seqCnt >= gate_sup_pkg::cnt_t'(MOTOR_CYCLES - 1)) begin
            cur_nxt.state  = gate_sup_pkg::ST_OPER;
            cur_nxt.seqCnt = '0;
          end
        end else begin
          cur_nxt.seqCnt = '0;
        end
        if (lowDone) begin
          cur_nxt.state = configRegZero.sleep ? gate_sup_pkg::ST_SLEEP
                                              : gate_sup_pkg::ST_STANDBY;
        end
      end
      gate_sup_pkg::ST_OPER: begin
        cur_nxt.seqCnt = '0;
        if (lowDone) begin
          cur_nxt.state = configRegZero.sleep ? gate_sup_pkg::ST_SLEEP
                                              : gate_sup_pkg::ST_STANDBY;
        end
      end
      default: begin
        cur_nxt.state  = gate_sup_pkg::ST_POWERUP;
        cur_nxt.seqCnt = '0;
      end
    endcase

    // Gates follow PWM only while operational, enabled and fault free.
    driveOn = (cur_r.state == gate_sup_pkg::ST_OPER) && pin.enable
      && (cur_nxt.faults == gate_sup_pkg::NO_FAULTS);
    cur_nxt.gateHigh = driveOn ? pin.pwmHigh : gate_sup_pkg::PHASES_OFF;
    cur_nxt.gateLow  = driveOn ? pin.pwmLow : gate_sup_pkg::PHASES_OFF;

    // Every gate turn-on reopens the blanking window against switching spikes.
    gateRise = |((cur_nxt.gateHigh & ~cur_r.gateHigh) | (cur_nxt.gateLow & ~cur_r.gateLow));
    if (gateRise) begin
      cur_nxt.blankCnt = gate_sup_pkg::cnt_t'(gate_sup_pkg::BLANK_CYC);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_r           <= '0;
      cur_r.state     <= gate_sup_pkg::ST_POWERUP;
      cur_r.threshold <= gate_sup_pkg::SC_THR_RESET;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign gateHigh              = cur_r.gateHigh;
  assign gateLow               = cur_r.gateLow;
  assign shortCircuitThreshold = cur_r.threshold;
  assign powerState            = cur_r.state;
  assign faults                = cur_r.faults;
  assign faultActive           = cur_r.faults != gate_sup_pkg::NO_FAULTS;

endmodule

/* File: tb/gate_sup_sva.sv */
// Port checker of the gate driver supervisor.
// Assumes the four-flop pin synchroniser and the 10 MHz system clock.
`timescale 1ns/1ns
module gate_sup_sva (
  // Clock and reset
  input wire logic                           clk_sys,
  input wire logic                           rst,
  // Watched ports
  input wire gate_sup_pkg::pins_s            pins,
  input wire gate_sup_pkg::config_reg_zero_s configRegZero,
  input wire logic [2:0]                     gateHigh,
  input wire logic [2:0]                     gateLow,
  input wire logic [1:0]                     shortCircuitThreshold,
  input wire gate_sup_pkg::power_state_e     powerState,
  input wire gate_sup_pkg::fault_s           faults,
  input wire logic                           faultActive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic gatesOn;
  assign gatesOn = |{gateHigh, gateLow};
  a_gates_fault_free: assert property (gatesOn |-> !faultActive)
    else $error("gates on with a latched fault");
  a_gates_only_oper: assert property (gatesOn |-> powerState == gate_sup_pkg::ST_OPER)
    else $error("gates on outside operation");
  a_thr_copy: assert property (1'b1 |=> shortCircuitThreshold == $past(configRegZero.shortCircuitThreshold))
    else $error("threshold select not copied");
  a_enable_off: assert property ($fell(pins.enable) |-> ##[1:5] !gatesOn)
    else $error("gates not off after enable low");
  a_clear_keeps_state: assert property ($fell(faultActive) |-> $stable(powerState))
    else $error("fault clear changed state");
  a_uv_persist: assert property ($rose(faults.undervoltageLockout) |->
    $past(pins.undervoltageLockout, 12) && $past(pins.undervoltageLockout, 5))
    else $error("undervoltage latched too soon");
  a_ov_persist: assert property ($rose(faults.overvoltageLockout) |->
    $past(pins.overvoltageLockout, 30))
    else $error("overvoltage latched before 3 us");
  a_oc_prompt: assert property ($rose(pins.overcurrentProtection) |->
    ##[1:10] faults.overcurrentProtection)
    else $error("overcurrent not latched within 1 us");
  a_sleep_entry: assert property ($changed(powerState) && powerState == gate_sup_pkg::ST_SLEEP
    |-> $past(configRegZero.sleep))
    else $error("sleep entered with sleep bit clear");
  c_oper: cover property (powerState == gate_sup_pkg::ST_OPER);
  c_sleep: cover property (powerState == gate_sup_pkg::ST_SLEEP);
  c_clear: cover property ($fell(faultActive));
endmodule
bind gate_driver_fault_state_supervisor gate_sup_sva u_sva (
  .clk_sys(clk_sys), .rst(rst), .pins(pins), .configRegZero(configRegZero),
  .gateHigh(gateHigh), .gateLow(gateLow), .shortCircuitThreshold(shortCircuitThreshold),
  .powerState(powerState), .faults(faults), .faultActive(faultActive));

/* File: tb/mcu_model.sv */
// Controller model driving the enable and PWM pins.
// Assumes the bench requests levels; pins move just after a clock edge.
`timescale 1ns/1ns
module mcu_model (
  // Clock
  input  wire logic       clk_sys,
  // Requests from the bench
  input  wire logic       wantEn,
  input  wire logic [2:0] wantPwm,
  // Pins towards the supervisor
  output logic            enable,
  output logic [2:0]      pwmHigh,
  output logic [2:0]      pwmLow
);
  initial {enable, pwmHigh, pwmLow} = 7'h0;
  // PWM idles low while disabled, as the pull-downs would leave it.
  always @(posedge clk_sys) begin
    enable  <= wantEn;
    pwmHigh <= wantEn ? wantPwm : 3'h0;
    pwmLow  <= wantEn ? ~wantPwm : 3'h0;
  end
endmodule

/* File: tb/gate_driver_fault_state_supervisor_tb.sv */
// Self-checking bench of the gate driver supervisor.
// Assumes the shortened count parameters set at the instance.
`timescale 1ns/1ns
module gate_driver_fault_state_supervisor_tb;
  logic clk_sys, rst, wantEn, enable, ov, uv, oc, fa;
  logic [2:0] wantPwm, pwmHigh, pwmLow, scHigh, gateHigh, gateLow;
  logic [1:0] thr;
  gate_sup_pkg::config_reg_zero_s cfg;
  gate_sup_pkg::power_state_e     state;
  gate_sup_pkg::fault_s           flt;
  int err_total = 0;
  int cmp_count = 0;
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  mcu_model u_mcu (.clk_sys(clk_sys), .wantEn(wantEn), .wantPwm(wantPwm), .enable(enable),
    .pwmHigh(pwmHigh), .pwmLow(pwmLow));
  gate_driver_fault_state_supervisor #(.POWER_CYCLES(20), .MOTOR_CYCLES(15),
    .ENLOW_CYCLES(40), .CLRMAX_CYCLES(30)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .pins({enable, pwmHigh, pwmLow, scHigh, 3'h0, ov, uv, oc, 1'b0}), .configRegZero(cfg),
    .gateHigh(gateHigh), .gateLow(gateLow), .shortCircuitThreshold(thr),
    .powerState(state), .faults(flt), .faultActive(fa));
  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Compares at the falling edge so the rising edge's updates have landed.
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
    @(posedge clk_sys);
  endtask
  task automatic chk_state(input gate_sup_pkg::power_state_e e);
    @(negedge clk_sys);
    cmp({5'h0, state}, {5'h0, e});
  endtask
  task automatic chk_gates(input logic [7:0] e);
    @(negedge clk_sys);
    cmp({2'h0, gateHigh, gateLow}, e);
  endtask
  task automatic chk_flt(input logic [7:0] e);
    @(negedge clk_sys);
    cmp({3'h0, flt}, e);
  endtask
  // The clear lands six edges after the request rises, behind the model and the synchroniser.
  task automatic clr_pulse(input int low);
    wantEn <= 1'b0;
    cyc(low);
    wantEn <= 1'b1;
    cyc(8);
  endtask
  task automatic t_power();
    cyc(10);
    chk_state(gate_sup_pkg::ST_POWERUP);
    cyc(15);
    chk_state(gate_sup_pkg::ST_STANDBY);
    for (int i = 0; i < 4; i++) begin
      cfg.shortCircuitThreshold <= 2'(i);
      cyc(2);
      @(negedge clk_sys);
      cmp({6'h0, thr}, 8'(i));
    end
  endtask
  task automatic t_arm();
    wantEn  <= 1'b1;
    wantPwm <= 3'h5;
    cyc(10);
    chk_state(gate_sup_pkg::ST_ARMING);
    cyc(20);
    chk_state(gate_sup_pkg::ST_OPER);
    chk_gates(8'h2a);
  endtask
  task automatic t_enoff();
    wantEn <= 1'b0;
    cyc(6);
    chk_gates(8'h00);
    cyc(25);
    chk_state(gate_sup_pkg::ST_OPER);
    cyc(25);
    chk_state(gate_sup_pkg::ST_STANDBY);
  endtask
  task automatic t_oc();
    oc <= 1'b1;
    cyc(10);
    chk_flt(8'h02);
    chk_gates(8'h00);
    @(negedge clk_sys);
    cmp({7'h0, fa}, 8'h01);
    oc <= 1'b0;
    clr_pulse(5);
    chk_flt(8'h02);
    clr_pulse(20);
    chk_flt(8'h00);
    @(negedge clk_sys);
    cmp({7'h0, fa}, 8'h00);
    chk_state(gate_sup_pkg::ST_OPER);
    chk_gates(8'h2a);
  endtask
  task automatic t_uv_ov();
    uv <= 1'b1;
    cyc(8);
    uv <= 1'b0;
    cyc(6);
    chk_flt(8'h00);
    uv <= 1'b1;
    cyc(20);
    chk_flt(8'h08);
    uv <= 1'b0;
    clr_pulse(20);
    ov <= 1'b1;
    cyc(30);
    chk_flt(8'h00);
    cyc(30);
    chk_flt(8'h04);
    ov <= 1'b0;
    clr_pulse(20);
  endtask
  task automatic t_sc_sleep();
    scHigh <= 3'h1;
    cyc(8);
    chk_flt(8'h10);
    chk_gates(8'h00);
    scHigh <= 3'h0;
    clr_pulse(20);
    cfg.sleep <= 1'b1;
    wantEn    <= 1'b0;
    cyc(50);
    chk_state(gate_sup_pkg::ST_SLEEP);
    wantEn <= 1'b1;
    cyc(8);
    chk_state(gate_sup_pkg::ST_POWERUP);
    cyc(25);
    chk_state(gate_sup_pkg::ST_ARMING);
  endtask
  // The tests need about 500 cycles; the limit leaves ample margin.
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
  initial begin
    {rst, wantEn, wantPwm, scHigh, ov, uv, oc} = 11'h400;
    cfg = '0;
    cyc(6);
    rst <= 1'b0;
    t_power();
    t_arm();
    t_enoff();
    t_arm();
    t_oc();
    t_uv_ov();
    t_sc_sleep();
    give_verdict();
  end
endmodule
